/* src/poll_responder_defs.svh */
/*
  Constants for the RS-485 poll and Modbus responder: frame bytes, field
  positions, limits and reset values.
  Assumes inclusion by every file that decodes or builds frames.
*/
`ifndef POLL_RESPONDER_DEFS_SVH
`define POLL_RESPONDER_DEFS_SVH

// ****************************************
// Poll protocol bytes
// ****************************************
`define CMD_POLL 8'h25
`define CMD_SLEEP 8'h2B
`define CMD_WAKE 8'h2D
`define RESP_HEAD 8'hA5
`define ASCII_ZERO 8'h30
`define ASCII_POINT 8'h2E
`define POLL_LAST_IDX 4'h3
`define TXT_MAX 13

// ****************************************
// Modbus bytes and limits
// ****************************************
`define FUNC_READ 8'h03
`define FUNC_WRITE 8'h06
`define MB_LAST_IDX 4'h7
`define MB_CRC_IDX 4'h6
`define MB_DATA_IDX 9'h003
`define MB_MAX_REGS 16'h007D
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define HOLD_REGS 16
`define HOLD_LIMIT 16'h0010
`define MILLI_MAX 10'h3E7

// ****************************************
// Reset values
// ****************************************
`define PSAVE_RST 1'b0
`define HOLD_RST 16'h0000

`endif

/* src/poll_responder_pkg.sv */
/*
  Types shared by the responder: its sequencing states.
  Assumes nothing of its surroundings.
*/
package poll_responder_pkg;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_RX = 3'b001,
    ST_TXBUF = 3'b010,
    ST_TXREG = 3'b100
  } state_t;

endpackage

/* src/rs485_poll_and_modbus_responder.sv */
/*
  Slave-side frame handler for a shared RS-485 line: ASCII poll protocol and
  Modbus RTU, with a 16-word transmit FIFO.
  Assumes a byte receiver and transmitter outside, synchronous to clk_sys;
  frame_gap pulses when the line has been idle long enough to end a frame.
*/
// What this block does
// - Velocity poll is byte 0x25, two identifier bytes, one checksum byte.
// - Identifier is two ASCII decimal digits; unit 2 is 0x30 0x32.
// - Request checksum is the modulo-256 sum of both identifier bytes.
// - Answer poll only on own identifier, carrying the current averaged velocity.
// - Response is 0xA5, two identifier bytes, speed text, one checksum.
// - Speed text has decimal point 0x2E and exactly three fractional digits.
// - Response checksum sums identifier bytes and all speed text bytes, modulo 256.
// - Request starting 0x2b puts the addressed device into power save.
// - Request starting 0x2d returns the addressed device to normal operation.
// - Never transmit unsolicited; reply only to a matching request.
// - Modbus characters are 8 data bits, even parity, one stop bit.
// - Registers are 16 bits; 1 to 125 consecutive registers per request.
// - Request: address, function, start high-low, count high-low, CRC low-high.
// - Read reply: address, function, byte count twice registers, data, CRC.
// - Modbus address byte is the sensor identifier; answer only that.
// - Function 0x03 reads holding registers, 0x06 writes one.
`timescale 1ns/100ps
`include "poll_responder_defs.svh"

// ****************************************
// Transmit FIFO
// ****************************************
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0] cnt_reg;
  logic push, pop;

  assign in_ready = cnt_reg != DEPTH[AW:0];
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) mem_reg[wr_reg] <= in_data;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
      if (push && !pop) cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push) cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

// ****************************************
// Responder
// ****************************************
module rs485_poll_and_modbus_responder import poll_responder_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic modbus_mode,
  input wire logic [6:0] unit_id,
  input wire logic [15:0] avg_speed_int,
  input wire logic [9:0] avg_speed_milli,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic frame_gap,
  output logic [7:0] tx_data,
  output logic tx_parity,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic power_save
);

  function automatic logic [19:0] to_bcd(input logic [15:0] bin);
    logic [19:0] bcd;
    bcd = '0;
    for (int i = 15; i >= 0; i--) begin
      for (int d = 0; d < 5; d++) begin
        if (bcd[4*d+:4] > 4'h4) bcd[4*d+:4] = bcd[4*d+:4] + 4'h3;
      end
      bcd = {bcd[18:0], bin[i]};
    end
    return bcd;
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  state_t state_reg;
  logic [7:0] rxb_reg [0:7];
  logic [7:0] txb_reg [0:`TXT_MAX-1];
  logic [7:0] txt [0:`TXT_MAX-1];
  logic [15:0] hold_reg [0:`HOLD_REGS-1];
  logic [3:0] rcnt_reg, tlen_reg, txt_len;
  logic [8:0] tidx_reg, mb_end, dat_off;
  logic [15:0] rcrc_reg, tcrc_reg, mstart_reg, mb_addr, mb_val, mb_count, rd_idx, rd_val;
  logic [6:0] mcount_reg;
  logic [19:0] id_bcd, int_bcd, frac_bcd;
  logic [7:0] id_hi, id_lo, fifo_in;
  logic done_reg, bad_reg, rx_acc, is_start, ascii_ok, mb_ok, fifo_in_ready, push;

  // ****************************************
  // Receive framing
  // ****************************************
  assign rx_ready = (state_reg == ST_RX) && !done_reg;
  assign rx_acc = rx_valid & rx_ready;
  assign is_start = rx_data == `CMD_POLL || rx_data == `CMD_SLEEP || rx_data == `CMD_WAKE;

  // Start bytes never occur as digits or checksums, so outside Modbus mode a start byte resyncs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rcnt_reg <= '0;
      done_reg <= 1'b0;
      bad_reg <= 1'b0;
      rcrc_reg <= `CRC_INIT;
      for (int i = 0; i < 8; i++) rxb_reg[i] <= 8'h00;
    end else if (done_reg || frame_gap) begin
      rcnt_reg <= '0;
      done_reg <= 1'b0;
      bad_reg <= 1'b0;
      rcrc_reg <= `CRC_INIT;
    end else if (rx_acc && modbus_mode) begin
      rxb_reg[rcnt_reg[2:0]] <= rx_data;
      rcnt_reg <= rcnt_reg + 4'h1;
      bad_reg <= bad_reg | (^{rx_data, rx_parity});
      if (rcnt_reg < `MB_CRC_IDX) rcrc_reg <= crc_step(rcrc_reg, rx_data);
      done_reg <= rcnt_reg == `MB_LAST_IDX;
    end else if (rx_acc && is_start) begin
      rxb_reg[0] <= rx_data;
      rcnt_reg <= 4'h1;
    end else if (rx_acc && rcnt_reg != 4'h0) begin
      rxb_reg[rcnt_reg[2:0]] <= rx_data;
      rcnt_reg <= rcnt_reg + 4'h1;
      done_reg <= rcnt_reg == `POLL_LAST_IDX;
    end
  end

  // ****************************************
  // Frame checks
  // ****************************************
  assign id_bcd = to_bcd({9'h000, unit_id});
  assign id_hi = `ASCII_ZERO | {4'h0, id_bcd[7:4]};
  assign id_lo = `ASCII_ZERO | {4'h0, id_bcd[3:0]};
  assign ascii_ok = rxb_reg[1] == id_hi && rxb_reg[2] == id_lo
    && rxb_reg[3] == 8'(rxb_reg[1] + rxb_reg[2]);
  assign mb_ok = rxb_reg[0] == {1'b0, unit_id}
    && {rxb_reg[7], rxb_reg[6]} == rcrc_reg && !bad_reg;
  assign mb_addr = {rxb_reg[2], rxb_reg[3]};
  assign mb_val = {rxb_reg[4], rxb_reg[5]};
  assign mb_count = {rxb_reg[4], rxb_reg[5]};

  // ****************************************
  // Speed text
  // ****************************************
  assign int_bcd = to_bcd(avg_speed_int);
  assign frac_bcd = to_bcd({6'h00,
    (avg_speed_milli > `MILLI_MAX) ? `MILLI_MAX : avg_speed_milli});

  // Leading zeros of the integer part are suppressed, one digit always kept
  always_comb begin
    logic [3:0] k;
    logic lead;
    logic [7:0] sum;
    k = 4'h3;
    lead = 1'b0;
    sum = 8'h00;
    for (int i = 0; i < `TXT_MAX; i++) txt[i] = 8'h00;
    txt[0] = `RESP_HEAD;
    txt[1] = id_hi;
    txt[2] = id_lo;
    for (int d = 4; d >= 0; d--) begin
      if (int_bcd[4*d+:4] != 4'h0 || lead || d == 0) begin
        txt[k] = `ASCII_ZERO | {4'h0, int_bcd[4*d+:4]};
        k = k + 4'h1;
        lead = 1'b1;
      end
    end
    txt[k] = `ASCII_POINT;
    k = k + 4'h1;
    for (int d = 2; d >= 0; d--) begin
      txt[k] = `ASCII_ZERO | {4'h0, frac_bcd[4*d+:4]};
      k = k + 4'h1;
    end
    for (int i = 1; i < `TXT_MAX - 1; i++) begin
      if (i < k) sum = sum + txt[i];
    end
    txt[k] = sum;
    txt_len = k + 4'h1;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  assign mb_end = `MB_DATA_IDX + {1'b0, mcount_reg, 1'b0};
  assign dat_off = tidx_reg - `MB_DATA_IDX;
  assign rd_idx = mstart_reg + {8'h00, dat_off[8:1]};
  assign rd_val = (rd_idx == 16'h0000) ? {9'h000, unit_id}
    : (rd_idx < `HOLD_LIMIT) ? hold_reg[rd_idx[3:0]] : 16'h0000;

  always_comb begin
    fifo_in = 8'h00;
    if (state_reg == ST_TXBUF) fifo_in = txb_reg[tidx_reg[3:0]];
    else if (tidx_reg == 9'h000) fifo_in = {1'b0, unit_id};
    else if (tidx_reg == 9'h001) fifo_in = `FUNC_READ;
    else if (tidx_reg == 9'h002) fifo_in = {mcount_reg, 1'b0};
    else if (tidx_reg == mb_end) fifo_in = tcrc_reg[7:0];
    else if (tidx_reg > mb_end) fifo_in = tcrc_reg[15:8];
    else fifo_in = dat_off[0] ? rd_val[7:0] : rd_val[15:8];
  end

  assign push = (state_reg != ST_RX) && fifo_in_ready;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_RX;
      tidx_reg <= '0;
      tlen_reg <= '0;
      tcrc_reg <= `CRC_INIT;
      mstart_reg <= '0;
      mcount_reg <= '0;
      for (int i = 0; i < `TXT_MAX; i++) txb_reg[i] <= 8'h00;
    end else begin
      case (state_reg)
        ST_RX: begin
          tidx_reg <= '0;
          tcrc_reg <= `CRC_INIT;
          if (done_reg && !modbus_mode && rxb_reg[0] == `CMD_POLL && ascii_ok) begin
            txb_reg <= txt;
            tlen_reg <= txt_len;
            state_reg <= ST_TXBUF;
          end else if (done_reg && modbus_mode && mb_ok && rxb_reg[1] == `FUNC_WRITE) begin
            for (int i = 0; i < 8; i++) txb_reg[i] <= rxb_reg[i];
            tlen_reg <= 4'h8;
            state_reg <= ST_TXBUF;
          end else if (done_reg && modbus_mode && mb_ok && rxb_reg[1] == `FUNC_READ
              && mb_count != 16'h0000 && mb_count <= `MB_MAX_REGS) begin
            mstart_reg <= mb_addr;
            mcount_reg <= mb_count[6:0];
            state_reg <= ST_TXREG;
          end
        end
        ST_TXBUF: begin
          if (push) begin
            tidx_reg <= tidx_reg + 9'h001;
            if (tidx_reg[3:0] == tlen_reg - 4'h1) state_reg <= ST_RX;
          end
        end
        ST_TXREG: begin
          if (push) begin
            tidx_reg <= tidx_reg + 9'h001;
            if (tidx_reg < mb_end) tcrc_reg <= crc_step(tcrc_reg, fifo_in);
            if (tidx_reg > mb_end) state_reg <= ST_RX;
          end
        end
        default: state_reg <= ST_RX;
      endcase
    end
  end

  // ****************************************
  // Holding registers and power save
  // ****************************************
  // Register 0 reads back the identifier and ignores writes
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `HOLD_REGS; i++) hold_reg[i] <= `HOLD_RST;
    end else if (state_reg == ST_RX && done_reg && modbus_mode && mb_ok
        && rxb_reg[1] == `FUNC_WRITE && mb_addr < `HOLD_LIMIT && mb_addr != 16'h0000) begin
      hold_reg[mb_addr[3:0]] <= mb_val;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      power_save <= `PSAVE_RST;
    end else if (done_reg && !modbus_mode && ascii_ok && rxb_reg[0] == `CMD_SLEEP) begin
      power_save <= 1'b1;
    end else if (done_reg && !modbus_mode && ascii_ok && rxb_reg[0] == `CMD_WAKE) begin
      power_save <= 1'b0;
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************
  // Parity travels with the byte so the transmitter needs no second look
  byte_fifo #(.WIDTH(9), .DEPTH(16)) u_txq (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_data({^fifo_in, fifo_in}),
    .in_valid(state_reg != ST_RX),
    .in_ready(fifo_in_ready),
    .out_data({tx_parity, tx_data}),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_no_unsolicited: assert property ((state_reg == ST_RX) ##1 (state_reg != ST_RX)
    |-> $past(done_reg)) else $error("Transmit began without a request");
  a_poll_answered: assert property (done_reg && !modbus_mode && rxb_reg[0] == `CMD_POLL
    && ascii_ok |=> state_reg == ST_TXBUF) else $error("Matching poll not answered");
  a_resp_head: assert property (push && state_reg == ST_TXBUF && tidx_reg == 9'h000
    && !modbus_mode |-> fifo_in == `RESP_HEAD) else $error("Response head byte wrong");
  a_point_pos: assert property (push && state_reg == ST_TXBUF && !modbus_mode
    && tidx_reg[3:0] == tlen_reg - 4'h5 |-> fifo_in == `ASCII_POINT)
    else $error("Decimal point misplaced");
  a_sleep_cmd: assert property (done_reg && !modbus_mode && ascii_ok
    && rxb_reg[0] == `CMD_SLEEP |=> power_save) else $error("Power save not entered");
  a_wake_cmd: assert property (done_reg && !modbus_mode && ascii_ok
    && rxb_reg[0] == `CMD_WAKE |=> !power_save) else $error("Power save not left");
  a_bad_sum_drop: assert property (done_reg && !modbus_mode
    && rxb_reg[3] != 8'(rxb_reg[1] + rxb_reg[2]) |=> state_reg == ST_RX && $stable(power_save))
    else $error("Bad checksum frame acted on");
  a_foreign_id: assert property (done_reg && modbus_mode
    && rxb_reg[0] != {1'b0, unit_id} |=> state_reg == ST_RX ##1 state_reg == ST_RX)
    else $error("Foreign address answered");
  a_byte_count: assert property (push && state_reg == ST_TXREG && tidx_reg == 9'h002
    |-> fifo_in == 8'(mb_count << 1)) else $error("Byte count wrong");
  a_crc_low: assert property (push && state_reg == ST_TXREG && tidx_reg == mb_end
    |-> fifo_in == tcrc_reg[7:0]) else $error("CRC low byte wrong");

  c_poll: cover property (state_reg == ST_TXBUF && !modbus_mode ##1 state_reg == ST_RX);
  c_mb_read: cover property (state_reg == ST_TXREG && mcount_reg == 7'h10);
  c_mb_write: cover property (state_reg == ST_TXBUF && modbus_mode);
  c_sleep: cover property ($rose(power_save));

endmodule

/* tb/logger_model.sv */
/*
  Data logger model: the RS-485 bus master facing the responder's byte streams.
  Assumes clk_sys edges only; drives its outputs 1 ns after a rising edge.
*/
`timescale 1ns/100ps
module logger_model (
  input wire logic clk_sys,
  output logic [7:0] rx_data,
  output logic rx_parity,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic frame_gap,
  input wire logic [7:0] tx_data,
  input wire logic tx_parity,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] got[$];
  logic [7:0] stall_pat = 8'hFF;
  logic took = 1'b0;
  int cyc = 0;
  int par_bad = 0;

  initial begin
    rx_data = 8'h00;
    rx_parity = 1'b0;
    rx_valid = 1'b0;
    frame_gap = 1'b0;
    tx_ready = 1'b1;
  end

  // ****************************************
  // Reply collection and stalling
  // ****************************************
  always @(posedge clk_sys) begin
    took <= rx_valid & rx_ready;
    if (tx_valid === 1'b1 && tx_ready) begin
      got.push_back(tx_data);
      if (tx_parity !== ^tx_data) par_bad++;
    end
    #1 tx_ready = stall_pat[cyc % 8];
    cyc++;
  end

  // ****************************************
  // Request sending
  // ****************************************
  // Valid and data stay up until taken; released data is inverted so that
  // a stale byte can never pass for a fresh one
  task automatic send_frame(input logic [7:0] f[$], input int bad_at);
    foreach (f[i]) begin
      rx_data = f[i];
      rx_parity = (^f[i]) ^ (i == bad_at);
      rx_valid = 1'b1;
      do begin
        @(posedge clk_sys);
        #1;
      end while (!took);
    end
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    rx_parity = ~rx_parity;
  endtask

  task automatic gap();
    frame_gap = 1'b1;
    @(posedge clk_sys);
    #1 frame_gap = 1'b0;
  endtask
endmodule

/* tb/tb_top.sv */
/*
  Self-checking bench for the poll and Modbus responder.
  Assumes the logger model drives the line side and collects replies.
*/
`timescale 1ns/100ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic modbus_mode = 1'b0;
  logic [6:0] unit_id = 7'h02;
  logic [15:0] avg_speed_int = 16'h0000;
  logic [9:0] avg_speed_milli = 10'h000;
  logic [7:0] rx_data, tx_data;
  logic rx_parity, rx_valid, rx_ready, frame_gap, tx_parity, tx_valid, tx_ready, power_save;
  logic [31:0] seed = 32'h6DBB89EC;
  logic [7:0] q[$], e[$];
  logic [15:0] regs[16];
  int failures = 0;
  int checks = 0;
  int s, m, v, a;

  always #10 clk_sys = ~clk_sys;

  rs485_poll_and_modbus_responder u_rs485_poll_and_modbus_responder (
    .clk_sys(clk_sys), .rstn(rstn), .modbus_mode(modbus_mode), .unit_id(unit_id),
    .avg_speed_int(avg_speed_int), .avg_speed_milli(avg_speed_milli),
    .rx_data(rx_data), .rx_parity(rx_parity), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .frame_gap(frame_gap), .tx_data(tx_data), .tx_parity(tx_parity),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .power_save(power_save));

  logger_model u_logger_model (
    .clk_sys(clk_sys), .rx_data(rx_data), .rx_parity(rx_parity), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .frame_gap(frame_gap), .tx_data(tx_data),
    .tx_parity(tx_parity), .tx_valid(tx_valid), .tx_ready(tx_ready));

  // ****************************************
  // Expectation helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] tens(input int id);
    return 8'(8'h30 + id / 10);
  endfunction

  function automatic logic [7:0] ones(input int id);
    return 8'(8'h30 + id % 10);
  endfunction

  function automatic logic [15:0] crc16(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c ^= {8'h00, f[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction

  task automatic ascii_req(input logic [7:0] cmd, input int id, input logic [7:0] cadj);
    q = {cmd, tens(id), ones(id), 8'(tens(id) + ones(id) + cadj)};
  endtask

  task automatic exp_speed(input int id, input int sp, input int ml);
    logic [7:0] sum;
    e = {8'hA5, tens(id), ones(id)};
    do begin
      e.insert(3, 8'(8'h30 + sp % 10));
      sp = sp / 10;
    end while (sp > 0);
    if (ml > 999) ml = 999;
    e = {e, 8'h2E, 8'(8'h30 + ml / 100), 8'(8'h30 + ml / 10 % 10), 8'(8'h30 + ml % 10)};
    sum = 8'h00;
    foreach (e[i]) if (i > 0) sum += e[i];
    e.push_back(sum);
  endtask

  task automatic mb_req(input logic [7:0] ad, fn, input logic [15:0] r, vv);
    logic [15:0] c;
    q = {ad, fn, r[15:8], r[7:0], vv[15:8], vv[7:0]};
    c = crc16(q);
    q = {q, c[7:0], c[15:8]};
  endtask

  task automatic exp_read(input int r, input int n);
    logic [15:0] c, x;
    e = {8'h01, 8'h03, 8'(2 * n)};
    for (int i = 0; i < n; i++) begin
      x = (r + i == 0) ? {9'h000, unit_id} : ((r + i < 16) ? regs[r + i] : 16'h0000);
      e = {e, x[15:8], x[7:0]};
    end
    c = crc16(e);
    e = {e, c[7:0], c[15:8]};
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Waits a bounded time for the whole reply, then also catches stray extras
  task automatic send_expect(input int bad_at);
    int n;
    u_logger_model.send_frame(q, bad_at);
    n = 0;
    while (u_logger_model.got.size() < e.size() && n < 900) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (40) @(posedge clk_sys);
    check(u_logger_model.got.size(), e.size());
    foreach (e[i]) if (i < u_logger_model.got.size()) check(u_logger_model.got[i], e[i]);
    u_logger_model.got.delete();
    #1;
  endtask

  task automatic report_and_stop();
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(20 * 40000);
    failures++;
    report_and_stop();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    foreach (regs[i]) regs[i] = 16'h0000;
    repeat (3) @(posedge clk_sys);
    #1 rstn = 1'b1;
    for (int t = 0; t < 6; t++) begin
      s = (t == 0) ? 0 : int'(rnd() % 65536);
      m = (t == 1) ? 1005 : ((t == 2) ? 7 : int'(rnd() % 1000));
      avg_speed_int = 16'(s);
      avg_speed_milli = 10'(m);
      u_logger_model.stall_pat = 8'(rnd()) | 8'h01;
      ascii_req(8'h25, 2, 8'h00);
      exp_speed(2, s, m);
      send_expect(-1);
    end
    e = {};
    ascii_req(8'h25, 3, 8'h00);
    send_expect(-1);
    ascii_req(8'h25, 2, 8'h01);
    send_expect(-1);
    ascii_req(8'h2B, 2, 8'h00);
    send_expect(-1);
    check(power_save, 1'b1);
    ascii_req(8'h2D, 3, 8'h00);
    send_expect(-1);
    check(power_save, 1'b1);
    ascii_req(8'h2D, 2, 8'h00);
    send_expect(-1);
    check(power_save, 1'b0);
    modbus_mode = 1'b1;
    unit_id = 7'h01;
    mb_req(8'h01, 8'h03, 16'h0000, 16'h0001);
    check({q[6], q[7]}, 16'h840A);
    e = {8'h01, 8'h03, 8'h02, 8'h00, 8'h01, 8'h79, 8'h84};
    send_expect(-1);
    for (int t = 0; t < 6; t++) begin
      a = (t == 0) ? 5 : ((t == 1) ? 0 : int'(rnd() % 20));
      v = int'(rnd() % 65536);
      mb_req(8'h01, 8'h06, 16'(a), 16'(v));
      e = q;
      if (a > 0 && a < 16) regs[a] = 16'(v);
      send_expect(-1);
    end
    u_logger_model.stall_pat = 8'h11;
    mb_req(8'h01, 8'h03, 16'h0000, 16'h0010);
    exp_read(0, 16);
    send_expect(-1);
    u_logger_model.stall_pat = 8'hFF;
    mb_req(8'h01, 8'h03, 16'h000E, 16'h0004);
    exp_read(14, 4);
    u_logger_model.send_frame(q[0:2], -1);
    u_logger_model.gap();
    send_expect(-1);
    e = {};
    for (int k = 0; k < 6; k++) begin
      mb_req(k == 2 ? 8'h02 : 8'h01, k == 3 ? 8'h04 : 8'h03, 16'h0000,
             k == 4 ? 16'h0000 : (k == 5 ? 16'h007E : 16'h0001));
      if (k == 0) q[7] = ~q[7];
      send_expect(k == 1 ? 3 : -1);
    end
    check(u_logger_model.par_bad, 0);
    report_and_stop();
  end
endmodule
